// ---- arpf_pkg.sv ----
package arpf_pkg;

  // Transaction codes as received on the bus
  localparam logic [3:0] TC_WRQ_QUAD = 4'h0;
  localparam logic [3:0] TC_WRQ_BLK = 4'h1;
  localparam logic [3:0] TC_WRS = 4'h2;
  localparam logic [3:0] TC_RDQ_QUAD = 4'h4;
  localparam logic [3:0] TC_RDQ_BLK = 4'h5;
  localparam logic [3:0] TC_RDS_QUAD = 4'h6;
  localparam logic [3:0] TC_RDS_BLK = 4'h7;
  localparam logic [3:0] TC_CONF = 4'h8;
  localparam logic [3:0] TC_LOCK_RQ = 4'h9;
  localparam logic [3:0] TC_STREAM = 4'hA;
  localparam logic [3:0] TC_LOCK_RS = 4'hB;
  localparam logic [3:0] TC_SELFID = 4'hE;

  // Acknowledge codes the link can generate
  localparam logic [3:0] ACK_COMPLETE = 4'h1;
  localparam logic [3:0] ACK_PENDING = 4'h2;
  localparam logic [3:0] ACK_BUSY_X = 4'h4;
  localparam logic [3:0] ACK_BUSY_A = 4'h5;
  localparam logic [3:0] ACK_BUSY_B = 4'h6;
  localparam logic [3:0] ACK_DATA_ERROR = 4'hD;
  localparam logic [3:0] ACK_TYPE_ERROR = 4'hE;

  // Stream reception status
  localparam logic [3:0] STREAM_OK = 4'h1;
  localparam logic [3:0] STREAM_BAD = 4'hD;

  // Header words written before the trailer of a no-data packet
  localparam logic [3:0] NODATA_HDR_WORDS = 4'h3;
  localparam logic [15:0] ZERO_LENGTH = 16'h0000;

  typedef enum logic [2:0] {
    FMT_NODATA = 3'b000,
    FMT_QUAD = 3'b001,
    FMT_BLOCK = 3'b010,
    FMT_SELFID = 3'b011,
    FMT_CONF = 3'b100,
    FMT_STREAM = 3'b101,
    FMT_BAD = 3'b110
  } arpf_fmt_t;

  // Acknowledge intent from the receive decision logic
  typedef enum logic [2:0] {
    ACKQ_COMPLETE = 3'b000,
    ACKQ_PENDING = 3'b001,
    ACKQ_BUSY_X = 3'b010,
    ACKQ_BUSY_A = 3'b011,
    ACKQ_BUSY_B = 3'b100,
    ACKQ_TYPE_ERR = 3'b101,
    ACKQ_PASS = 3'b110
  } arpf_ackreq_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_Q0 = 3'b001,
    S_Q1 = 3'b010,
    S_Q2 = 3'b011,
    S_Q3 = 3'b100,
    S_DATA = 3'b101,
    S_TRAIL = 3'b110
  } arpf_state_t;

  typedef struct packed {
    logic [3:0] tcode;
    logic [15:0] dest_id;
    logic [5:0] tlabel;
    logic [1:0] rt;
    logic [3:0] priority_lvl;
    logic [15:0] src_id;
    logic [15:0] offset_hi;
    logic [31:0] offset_lo;
    logic [3:0] rcode;
    logic [31:0] quad_data;
    logic [15:0] data_length;
    logic [15:0] ext_tcode;
    logic [1:0] tag;
    logic [5:0] channel;
    logic [3:0] sy;
    logic unsolicited;
    arpf_ackreq_t ack_req;
    logic [3:0] ack_raw;
    logic conf_from_resp;
  } arpf_hdr_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
    logic crc_bad;
  } arpf_byte_t;

  typedef struct packed {
    logic [31:0] data;
    logic last;
    logic crc_bad;
    logic [15:0] nbytes;
  } arpf_quad_t;

  typedef struct packed {
    logic [31:0] data;
    logic last;
    logic to_resp;
  } arpf_word_t;

  typedef struct packed {
    logic unsol;
    logic [26:0] rsvd;
    logic [3:0] code;
  } arpf_trailer_t;

  localparam arpf_word_t WORD_RESET = '0;
  localparam arpf_quad_t QUAD_RESET = '0;

  function automatic arpf_fmt_t fmt_of(input logic [3:0] tc);
    case (tc)
      TC_RDQ_QUAD, TC_WRS: fmt_of = FMT_NODATA;
      TC_WRQ_QUAD, TC_RDS_QUAD: fmt_of = FMT_QUAD;
      TC_RDQ_BLK, TC_WRQ_BLK, TC_RDS_BLK, TC_LOCK_RQ, TC_LOCK_RS: fmt_of = FMT_BLOCK;
      TC_SELFID: fmt_of = FMT_SELFID;
      TC_CONF: fmt_of = FMT_CONF;
      TC_STREAM: fmt_of = FMT_STREAM;
      default: fmt_of = FMT_BAD;
    endcase
  endfunction : fmt_of

  function automatic logic is_response(input logic [3:0] tc);
    is_response = (tc == TC_WRS) || (tc == TC_RDS_QUAD) || (tc == TC_RDS_BLK) ||
      (tc == TC_LOCK_RS);
  endfunction : is_response

  // Block codes that really carry payload; block read request does not
  function automatic logic has_payload(input logic [3:0] tc);
    has_payload = (tc == TC_WRQ_BLK) || (tc == TC_RDS_BLK) || (tc == TC_LOCK_RQ) ||
      (tc == TC_LOCK_RS);
  endfunction : has_payload

  function automatic logic [3:0] ack_code(input arpf_ackreq_t req, input logic [3:0] raw,
                                          input logic data_err, input logic resp);
    logic [3:0] c;
    c = ACK_COMPLETE;
    if (req == ACKQ_PASS) begin
      c = raw;
    end else if (data_err) begin
      c = ACK_DATA_ERROR;
    end else begin
      case (req)
        ACKQ_PENDING: c = resp ? ACK_COMPLETE : ACK_PENDING;
        ACKQ_BUSY_X: c = ACK_BUSY_X;
        ACKQ_BUSY_A: c = ACK_BUSY_A;
        ACKQ_BUSY_B: c = ACK_BUSY_B;
        ACKQ_TYPE_ERR: c = ACK_TYPE_ERROR;
        default: c = ACK_COMPLETE;
      endcase
    end
    return c;
  endfunction : ack_code

endpackage : arpf_pkg

// ---- arpf_quad_packer.sv ----
`timescale 1ns/1ps
module arpf_quad_packer (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire arpf_pkg::arpf_byte_t byte_in,
  input wire logic byte_valid_in,
  output logic byte_ready_out,
  output arpf_pkg::arpf_quad_t quad_out,
  output logic quad_valid_out,
  input wire logic quad_ready_in
);

  logic [1:0] lane_reg, lane_next;
  logic [31:0] acc_reg, acc_next;
  logic crc_reg, crc_next;
  logic [15:0] nbytes_reg, nbytes_next;
  arpf_pkg::arpf_quad_t quad_reg, quad_next;
  logic qvalid_reg, qvalid_next;

  // A byte may enter whenever the held quadlet is gone or leaving
  assign byte_ready_out = !qvalid_reg || quad_ready_in;
  assign quad_out = quad_reg;
  assign quad_valid_out = qvalid_reg;

  // Bytes fill from the top lane down; lower lanes stay zero as padding
  always_comb begin
    logic [31:0] word;
    logic [15:0] cnt;
    logic crc;
    word = acc_reg;
    cnt = nbytes_reg + 16'h0001;
    crc = crc_reg | byte_in.crc_bad;
    lane_next = lane_reg;
    acc_next = acc_reg;
    crc_next = crc_reg;
    nbytes_next = nbytes_reg;
    quad_next = quad_reg;
    qvalid_next = qvalid_reg && !quad_ready_in;
    if (byte_valid_in && byte_ready_out) begin
      word[(5'd24 - {lane_reg, 3'b000}) +: 8] = byte_in.data;
      if (lane_reg == 2'h3 || byte_in.last) begin
        quad_next = '{data: word, last: byte_in.last, crc_bad: crc, nbytes: cnt};
        qvalid_next = 1'b1;
        acc_next = 32'h0000_0000;
        lane_next = 2'h0;
        crc_next = byte_in.last ? 1'b0 : crc;
        nbytes_next = byte_in.last ? 16'h0000 : cnt;
      end else begin
        acc_next = word;
        lane_next = lane_reg + 2'h1;
        crc_next = crc;
        nbytes_next = cnt;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lane_reg <= 2'h0;
      acc_reg <= 32'h0000_0000;
      crc_reg <= 1'b0;
      nbytes_reg <= 16'h0000;
      quad_reg <= arpf_pkg::QUAD_RESET;
      qvalid_reg <= 1'b0;
    end else begin
      lane_reg <= lane_next;
      acc_reg <= acc_next;
      crc_reg <= crc_next;
      nbytes_reg <= nbytes_next;
      quad_reg <= quad_next;
      qvalid_reg <= qvalid_next;
    end
  end

endmodule : arpf_quad_packer

// ---- arpf_rx_formatter.sv ----
`timescale 1ns/1ps
// Function
// - Tcodes 4 and 2 stored header only
// - Tcodes 0 and 6 keep quadlet data
// - Tcodes 5,1,7,9,B use block format
// - Self-ID and PHY entries carry tcode E
// - Transmit confirmations carry tcode 8
// - Destination ID is bus plus node number
// - Transaction label kept with every entry except stream and self-ID
// - Received priority field is stored
// - Sender node ID stored as source ID
// - Offset high and low stored as address
// - Zero length block writes no data
// - First payload byte in top byte
// - Short payload padded with zero bytes
// - Unsolicited bit set for unsolicited responses
// - Returned acknowledge code stored in trailer
// - Stream status 0001 good, 1101 bad
// - Retry and response codes passed unchanged
// - Lock entries keep extended transaction code
// - Generated acks are defined codes only; no generated pending for responses
// - Reserved ack values passed through unchanged
// - Every entry ends with status trailer
// - Stream packets go to response queue
module arpf_rx_formatter (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire arpf_pkg::arpf_hdr_t hdr_in,
  input wire logic hdr_valid_in,
  output logic hdr_ready_out,
  input wire arpf_pkg::arpf_byte_t byte_in,
  input wire logic byte_valid_in,
  output logic byte_ready_out,
  output arpf_pkg::arpf_word_t word_out,
  output logic word_valid_out,
  input wire logic word_ready_in
);

  arpf_pkg::arpf_state_t state_reg, state_next;
  arpf_pkg::arpf_hdr_t hdr_reg, hdr_next;
  arpf_pkg::arpf_fmt_t fmt_reg, fmt_next;
  logic derr_reg, derr_next;
  arpf_pkg::arpf_word_t out_reg, out_next;
  logic out_valid_reg, out_valid_next;
  logic [3:0] emit_cnt_reg, emit_cnt_next;

  arpf_pkg::arpf_quad_t pk_quad;
  logic pk_valid;
  logic pk_ready;
  logic slot_free;
  logic emit;
  logic adv;
  logic resp;
  logic to_resp;
  logic len_zero;
  logic mismatch;
  logic [31:0] word;
  arpf_pkg::arpf_trailer_t trailer;

  // Payload bytes are packed into quadlets ahead of the sequencer
  arpf_quad_packer u_packer (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .byte_in(byte_in),
    .byte_valid_in(byte_valid_in),
    .byte_ready_out(byte_ready_out),
    .quad_out(pk_quad),
    .quad_valid_out(pk_valid),
    .quad_ready_in(pk_ready)
  );

  // Output handshake and packet attributes
  assign slot_free = !out_valid_reg || word_ready_in;
  assign adv = emit && slot_free;
  assign pk_ready = (state_reg == arpf_pkg::S_DATA) && slot_free;
  assign hdr_ready_out = (state_reg == arpf_pkg::S_IDLE);
  assign word_out = out_reg;
  assign word_valid_out = out_valid_reg;
  assign resp = arpf_pkg::is_response(hdr_reg.tcode);
  assign len_zero = (hdr_reg.data_length == arpf_pkg::ZERO_LENGTH);
  // Self-ID length is unknown ahead, so only alignment can be checked
  assign mismatch = (fmt_reg == arpf_pkg::FMT_SELFID) ? (pk_quad.nbytes[1:0] != 2'h0) :
    (pk_quad.nbytes != hdr_reg.data_length);

  // Queue choice: streams and responses to the response side
  always_comb begin
    case (fmt_reg)
      arpf_pkg::FMT_STREAM: to_resp = 1'b1;
      arpf_pkg::FMT_CONF: to_resp = hdr_reg.conf_from_resp;
      arpf_pkg::FMT_SELFID: to_resp = 1'b0;
      default: to_resp = resp;
    endcase
  end

  // Trailer word: unsolicited flag plus ack or stream status
  always_comb begin
    trailer = '0;
    trailer.unsol = resp && hdr_reg.unsolicited;
    if (fmt_reg == arpf_pkg::FMT_STREAM) begin
      trailer.code = derr_reg ? arpf_pkg::STREAM_BAD : arpf_pkg::STREAM_OK;
    end else begin
      trailer.code = arpf_pkg::ack_code(hdr_reg.ack_req, hdr_reg.ack_raw, derr_reg, resp);
    end
  end

  // Sequencer: one word per header or trailer state and per quadlet in S_DATA; S_IDLE moves on hdr_valid_in, others only when the output slot frees
  always_comb begin
    state_next = state_reg;
    hdr_next = hdr_reg;
    fmt_next = fmt_reg;
    derr_next = derr_reg;
    emit = 1'b0;
    word = 32'h0000_0000;
    case (state_reg)
      arpf_pkg::S_IDLE: begin
        if (hdr_valid_in) begin
          hdr_next = hdr_in;
          fmt_next = arpf_pkg::fmt_of(hdr_in.tcode);
          derr_next = 1'b0;
          // Unknown codes are dropped; nothing reaches the host
          state_next = (fmt_next == arpf_pkg::FMT_BAD) ? arpf_pkg::S_IDLE : arpf_pkg::S_Q0;
        end
      end
      arpf_pkg::S_Q0: begin
        emit = 1'b1;
        case (fmt_reg)
          arpf_pkg::FMT_STREAM: word = {hdr_reg.data_length, hdr_reg.tag, hdr_reg.channel,
            hdr_reg.tcode, hdr_reg.sy};
          arpf_pkg::FMT_SELFID: word = {24'h00_0000, arpf_pkg::TC_SELFID, 4'h0};
          arpf_pkg::FMT_CONF: word = {16'h0000, hdr_reg.tlabel, hdr_reg.rt,
            arpf_pkg::TC_CONF, 4'h0};
          default: word = {hdr_reg.dest_id, hdr_reg.tlabel, hdr_reg.rt, hdr_reg.tcode,
            hdr_reg.priority_lvl};
        endcase
        if (adv) begin
          case (fmt_reg)
            arpf_pkg::FMT_CONF: state_next = arpf_pkg::S_TRAIL;
            arpf_pkg::FMT_STREAM: state_next = len_zero ? arpf_pkg::S_TRAIL : arpf_pkg::S_DATA;
            arpf_pkg::FMT_SELFID: state_next = arpf_pkg::S_DATA;
            default: state_next = arpf_pkg::S_Q1;
          endcase
        end
      end
      arpf_pkg::S_Q1: begin
        emit = 1'b1;
        word = resp ? {hdr_reg.src_id, hdr_reg.rcode, 12'h000} :
          {hdr_reg.src_id, hdr_reg.offset_hi};
        if (adv) begin
          state_next = arpf_pkg::S_Q2;
        end
      end
      arpf_pkg::S_Q2: begin
        emit = 1'b1;
        word = resp ? 32'h0000_0000 : hdr_reg.offset_lo;
        if (adv) begin
          state_next = (fmt_reg == arpf_pkg::FMT_NODATA) ? arpf_pkg::S_TRAIL :
            arpf_pkg::S_Q3;
        end
      end
      arpf_pkg::S_Q3: begin
        emit = 1'b1;
        if (fmt_reg == arpf_pkg::FMT_QUAD) begin
          word = hdr_reg.quad_data;
        end else if ((hdr_reg.tcode == arpf_pkg::TC_LOCK_RQ) ||
                     (hdr_reg.tcode == arpf_pkg::TC_LOCK_RS)) begin
          word = {hdr_reg.data_length, hdr_reg.ext_tcode};
        end else begin
          word = {hdr_reg.data_length, 16'h0000};
        end
        if (adv) begin
          state_next = ((fmt_reg == arpf_pkg::FMT_BLOCK) && !len_zero &&
            arpf_pkg::has_payload(hdr_reg.tcode)) ? arpf_pkg::S_DATA : arpf_pkg::S_TRAIL;
        end
      end
      arpf_pkg::S_DATA: begin
        emit = pk_valid;
        word = pk_quad.data;
        if (adv && pk_quad.last) begin
          derr_next = pk_quad.crc_bad || mismatch;
          state_next = arpf_pkg::S_TRAIL;
        end
      end
      arpf_pkg::S_TRAIL: begin
        emit = 1'b1;
        word = trailer;
        if (adv) begin
          state_next = arpf_pkg::S_IDLE;
        end
      end
      default: state_next = arpf_pkg::S_IDLE;
    endcase
  end

  // Output register; data leaves from flops only
  always_comb begin
    out_next = out_reg;
    out_valid_next = out_valid_reg && !word_ready_in;
    emit_cnt_next = emit_cnt_reg;
    if (adv) begin
      out_next = '{data: word, last: (state_reg == arpf_pkg::S_TRAIL), to_resp: to_resp};
      out_valid_next = 1'b1;
      emit_cnt_next = (state_reg == arpf_pkg::S_TRAIL) ? 4'h0 : emit_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= arpf_pkg::S_IDLE;
      hdr_reg <= '0;
      fmt_reg <= arpf_pkg::FMT_NODATA;
      derr_reg <= 1'b0;
      out_reg <= arpf_pkg::WORD_RESET;
      out_valid_reg <= 1'b0;
      emit_cnt_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      hdr_reg <= hdr_next;
      fmt_reg <= fmt_next;
      derr_reg <= derr_next;
      out_reg <= out_next;
      out_valid_reg <= out_valid_next;
      emit_cnt_reg <= emit_cnt_next;
    end
  end

  // Checks on the sequencer and the words it hands out
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_nodata_hdr_len: assert property (
    (adv && state_reg == arpf_pkg::S_TRAIL && fmt_reg == arpf_pkg::FMT_NODATA)
      |-> emit_cnt_reg == arpf_pkg::NODATA_HDR_WORDS)
    else $error("no-data entry has wrong header length");

  a_quad_data_kept: assert property (
    (adv && state_reg == arpf_pkg::S_Q3 && fmt_reg == arpf_pkg::FMT_QUAD)
      |=> out_reg.data == $past(hdr_reg.quad_data))
    else $error("quadlet data not stored");

  a_block_fmt_pick: assert property (
    (state_reg == arpf_pkg::S_IDLE && hdr_valid_in && hdr_in.tcode == arpf_pkg::TC_RDQ_BLK)
      |=> fmt_reg == arpf_pkg::FMT_BLOCK && state_reg == arpf_pkg::S_Q0)
    else $error("block read request not in block format");

  a_selfid_tcode: assert property (
    (adv && state_reg == arpf_pkg::S_Q0 && fmt_reg == arpf_pkg::FMT_SELFID)
      |=> out_reg.data[7:4] == arpf_pkg::TC_SELFID && state_reg == arpf_pkg::S_DATA)
    else $error("self-ID entry lacks its tcode");

  a_conf_tcode: assert property (
    (adv && state_reg == arpf_pkg::S_Q0 && fmt_reg == arpf_pkg::FMT_CONF)
      |=> out_reg.data[7:4] == arpf_pkg::TC_CONF && state_reg == arpf_pkg::S_TRAIL)
    else $error("confirmation entry malformed");

  a_zero_len_skip: assert property (
    (adv && state_reg == arpf_pkg::S_Q3 && len_zero) |=> state_reg == arpf_pkg::S_TRAIL)
    else $error("zero length block wrote data");

  a_pad_zero: assert property (
    (pk_valid && pk_quad.last && pk_quad.nbytes[1:0] == 2'h1)
      |-> pk_quad.data[23:0] == 24'h00_0000)
    else $error("padding bytes not zero");

  a_unsol_clear: assert property (
    (adv && state_reg == arpf_pkg::S_TRAIL && !resp) |=> !out_reg.data[31] && out_reg.last)
    else $error("unsolicited flag set on non-response");

  a_no_pend_resp: assert property (
    (adv && state_reg == arpf_pkg::S_TRAIL && resp && hdr_reg.ack_req != arpf_pkg::ACKQ_PASS)
      |=> out_reg.data[3:0] != arpf_pkg::ACK_PENDING)
    else $error("pending returned for a response");

  // Judged on the word loaded, since a held word may belong to the previous entry
  a_stream_queue: assert property (
    (adv && fmt_reg == arpf_pkg::FMT_STREAM) |=> out_reg.to_resp)
    else $error("stream packet sent to request queue");

  c_stream_done: cover property (adv && state_reg == arpf_pkg::S_TRAIL &&
    fmt_reg == arpf_pkg::FMT_STREAM);
  c_block_data: cover property (adv && state_reg == arpf_pkg::S_DATA && pk_quad.last);
  c_selfid_err: cover property (state_reg == arpf_pkg::S_TRAIL && derr_reg &&
    fmt_reg == arpf_pkg::FMT_SELFID);
  c_out_stall: cover property ((out_valid_reg && !word_ready_in) [*3]);

endmodule : arpf_rx_formatter

// ---- arpf_host_model.sv ----
`timescale 1ns/1ps
// Host reading the receive queues; can stall to push back on the formatter
module arpf_host_model (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire arpf_pkg::arpf_word_t word_in,
  input wire logic word_valid_in,
  input wire logic stall_in,
  output logic word_ready_out
);
  arpf_pkg::arpf_word_t got[$];
  logic [1:0] phase_reg;
  // Slow host accepts one cycle in three; never ready while in reset
  assign word_ready_out = rst_n_in && (!stall_in || phase_reg == 2'h2);
  // Every accepted word is collected in got; the trailer closes each entry
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
      if (word_valid_in && word_ready_out) begin
        got.push_back(word_in);
      end
    end
  end
endmodule : arpf_host_model

// ---- test_async_receive_packet_formatter.sv ----
`timescale 1ns/1ps
module test_async_receive_packet_formatter;
  typedef struct {
    logic [3:0] tc;
    logic [15:0] len;
    int nb;
    logic [2:0] aq;
    logic [3:0] raw;
    logic u;
    logic crc;
    logic cfr;
  } arpf_row_t;
  logic core_clk_in, rst_n_in, hdr_valid_in, byte_valid_in, stall;
  logic hdr_ready_out, byte_ready_out, word_valid_out, word_ready_in;
  arpf_pkg::arpf_hdr_t hdr_in, h;
  arpf_pkg::arpf_byte_t byte_in;
  arpf_pkg::arpf_word_t word_out;
  arpf_pkg::arpf_word_t exp_q[$];
  logic q_exp;
  int failures, checked, cycles;
  // Ordinary cases: tcode, length, bytes sent, ack intent, raw ack, u, crc, conf queue
  arpf_row_t rows[17] = '{
    '{4'h4, 16'h0000, 0, 3'h2, 4'h0, 1'b1, 1'b0, 1'b0},
    '{4'h2, 16'h0000, 0, 3'h1, 4'h0, 1'b1, 1'b0, 1'b0},
    '{4'h0, 16'h0000, 0, 3'h1, 4'h0, 1'b0, 1'b0, 1'b0},
    '{4'h6, 16'h0000, 0, 3'h0, 4'h0, 1'b0, 1'b0, 1'b0},
    '{4'h5, 16'h0010, 0, 3'h3, 4'h0, 1'b0, 1'b0, 1'b0},
    '{4'h1, 16'h0005, 5, 3'h4, 4'h0, 1'b0, 1'b0, 1'b0},
    '{4'h7, 16'h0000, 0, 3'h5, 4'h0, 1'b1, 1'b0, 1'b0},
    '{4'h9, 16'h0008, 8, 3'h6, 4'hF, 1'b0, 1'b0, 1'b0},
    '{4'hB, 16'h0004, 4, 3'h0, 4'h0, 1'b1, 1'b1, 1'b0},
    '{4'hA, 16'h0003, 3, 3'h0, 4'h0, 1'b0, 1'b0, 1'b0},
    '{4'hA, 16'h0002, 2, 3'h0, 4'h0, 1'b0, 1'b1, 1'b0},
    '{4'hA, 16'h0000, 0, 3'h0, 4'h0, 1'b0, 1'b0, 1'b0},
    '{4'hE, 16'h0008, 8, 3'h0, 4'h0, 1'b0, 1'b0, 1'b0},
    '{4'hE, 16'h0005, 5, 3'h0, 4'h0, 1'b0, 1'b0, 1'b0},
    '{4'h8, 16'h0000, 0, 3'h6, 4'h2, 1'b0, 1'b0, 1'b1},
    '{4'h8, 16'h0000, 0, 3'h6, 4'hC, 1'b0, 1'b0, 1'b0},
    '{4'h1, 16'h0007, 6, 3'h0, 4'h0, 1'b0, 1'b0, 1'b0}};

  arpf_rx_formatter DUT (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .hdr_in(hdr_in),
    .hdr_valid_in(hdr_valid_in), .hdr_ready_out(hdr_ready_out), .byte_in(byte_in),
    .byte_valid_in(byte_valid_in), .byte_ready_out(byte_ready_out), .word_out(word_out),
    .word_valid_out(word_valid_out), .word_ready_in(word_ready_in));
  arpf_host_model host (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .word_in(word_out),
    .word_valid_in(word_valid_out), .stall_in(stall), .word_ready_out(word_ready_in));

  // Free-running 100 MHz clock
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  task automatic cmp_word(input string what, input arpf_pkg::arpf_word_t e,
                          input arpf_pkg::arpf_word_t s);
    checked++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, e, s);
    end
  endtask : cmp_word

  task automatic cmp_bit(input string what, input logic e, input logic s);
    checked++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %b seen %b", what, e, s);
    end
  endtask : cmp_bit

  task automatic cmp_cnt(input string what, input int e, input int s);
    checked++;
    if (s != e) begin
      failures++;
      $display("[ERR] %s expected %0d seen %0d", what, e, s);
    end
  endtask : cmp_cnt

  task automatic give_verdict;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  // Distinct field values per packet so a swapped field shows up
  function automatic arpf_pkg::arpf_hdr_t mk_hdr(input arpf_row_t r, input int i);
    arpf_pkg::arpf_hdr_t x;
    x = '0;
    x.tcode = r.tc;
    x.dest_id = 16'hFFC0 + i[15:0];
    x.tlabel = i[5:0];
    x.rt = 2'h1;
    x.priority_lvl = i[3:0];
    x.src_id = 16'h1200 + i[15:0];
    x.offset_hi = 16'hFFFF;
    x.offset_lo = 32'hF000_0400 + {i[29:0], 2'b00};
    x.rcode = 4'h6;
    x.quad_data = 32'hCAFE_0000 + i;
    x.data_length = r.len;
    x.ext_tcode = 16'h0003;
    x.tag = 2'h1;
    x.channel = 6'h2A;
    x.sy = 4'h3;
    x.unsolicited = r.u;
    x.ack_req = arpf_pkg::arpf_ackreq_t'(r.aq);
    x.ack_raw = r.raw;
    x.conf_from_resp = r.cfr;
    return x;
  endfunction : mk_hdr

  task automatic put(input logic [31:0] d, input logic l);
    exp_q.push_back('{d, l, q_exp});
  endtask : put

  // Expected entry built from field meanings, layouts and ack rules
  task automatic expect_pkt(input arpf_row_t r, input arpf_pkg::arpf_hdr_t x);
    logic resp, derr;
    logic [3:0] code;
    logic [31:0] d;
    int w, b;
    exp_q.delete();
    resp = (r.tc == 4'h2) || (r.tc == 4'h6) || (r.tc == 4'h7) || (r.tc == 4'hB);
    q_exp = (r.tc == 4'hA) ? 1'b1 : (r.tc == 4'hE) ? 1'b0 : (r.tc == 4'h8) ? r.cfr : resp;
    derr = (r.tc inside {4'h1, 4'h7, 4'h9, 4'hB, 4'hA, 4'hE}) &&
      (r.crc || ((r.tc == 4'hE) ? (r.nb % 4 != 0) : (r.nb != r.len)));
    if (r.tc == 4'hA) code = derr ? 4'hD : 4'h1;
    else if (r.aq == 3'h6) code = r.raw;
    else if (derr) code = 4'hD;
    else case (r.aq)
      3'h1: code = resp ? 4'h1 : 4'h2;
      3'h2: code = 4'h4;
      3'h3: code = 4'h5;
      3'h4: code = 4'h6;
      3'h5: code = 4'hE;
      default: code = 4'h1;
    endcase
    case (r.tc)
      4'hA: put({x.data_length, x.tag, x.channel, 4'hA, x.sy}, 1'b0);
      4'hE: put({24'h00_0000, 4'hE, 4'h0}, 1'b0);
      4'h8: put({16'h0000, x.tlabel, x.rt, 4'h8, 4'h0}, 1'b0);
      default: put({x.dest_id, x.tlabel, x.rt, x.tcode, x.priority_lvl}, 1'b0);
    endcase
    if (!(r.tc inside {4'h8, 4'hA, 4'hE})) begin
      put(resp ? {x.src_id, x.rcode, 12'h000} : {x.src_id, x.offset_hi}, 1'b0);
      put(resp ? 32'h0000_0000 : x.offset_lo, 1'b0);
      if (r.tc inside {4'h0, 4'h6}) put(x.quad_data, 1'b0);
      else if (!(r.tc inside {4'h4, 4'h2}))
        put({x.data_length, (r.tc inside {4'h9, 4'hB}) ? x.ext_tcode : 16'h0000}, 1'b0);
    end
    for (w = 0; w < (r.nb + 3) / 4; w++) begin
      d = 32'h0000_0000;
      for (b = 0; b < 4; b++)
        if (w * 4 + b < r.nb) d[31 - 8 * b -: 8] = 8'(8'hA0 + w * 4 + b);
      put(d, 1'b0);
    end
    put({resp && r.u, 27'h000_0000, code}, 1'b1);
  endtask : expect_pkt

  // Header held until taken; ready is stable between edges so it is judged at negedge
  task automatic send_hdr(input arpf_pkg::arpf_hdr_t x);
    int k;
    hdr_in = x;
    hdr_valid_in = 1'b1;
    for (k = 0; k < 500 && hdr_ready_out !== 1'b1; k++) @(negedge core_clk_in);
    @(negedge core_clk_in);
    hdr_valid_in = 1'b0;
  endtask : send_hdr

  task automatic send_bytes(input int nb, input logic crc);
    int i, k;
    for (i = 0; i < nb; i++) begin
      byte_in = '{8'hA0 + i[7:0], i == nb - 1, crc && (i == nb - 1)};
      byte_valid_in = 1'b1;
      for (k = 0; k < 500 && byte_ready_out !== 1'b1; k++) @(negedge core_clk_in);
      @(negedge core_clk_in);
    end
    byte_valid_in = 1'b0;
  endtask : send_bytes

  task automatic run_row(input arpf_row_t r, input int i);
    int k, j;
    h = mk_hdr(r, i);
    expect_pkt(r, h);
    send_hdr(h);
    cmp_bit("hdr_ready while busy", 1'b0, hdr_ready_out);
    send_bytes(r.nb, r.crc);
    for (k = 0; k < 600 && !(host.got.size() > 0 && host.got[$].last === 1'b1); k++)
      @(negedge core_clk_in);
    repeat (3) @(negedge core_clk_in);
    cmp_cnt("word count", exp_q.size(), host.got.size());
    for (j = 0; j < exp_q.size() && j < host.got.size(); j++)
      cmp_word($sformatf("word %0d", j), exp_q[j],
        host.got[j]);
    host.got.delete();
  endtask : run_row

  // Hang guard; whole run needs well under a thousand cycles
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end

  initial begin
    rst_n_in = 1'b0;
    hdr_valid_in = 1'b0;
    byte_valid_in = 1'b0;
    hdr_in = '0;
    byte_in = '0;
    stall = 1'b0;
    repeat (12) @(negedge core_clk_in);
    cmp_bit("word_valid in reset", 1'b0, word_valid_out);
    cmp_bit("hdr_ready in reset", 1'b1, hdr_ready_out);
    rst_n_in = 1'b1;
    @(negedge core_clk_in);
    // Table of formats; odd rows meet a stalling host
    foreach (rows[i]) begin
      stall = i[0];
      run_row(rows[i], i);
    end
    // Unknown tcode leaves nothing behind, then next packet follows ten cycles later
    stall = 1'b0;
    h = mk_hdr(rows[0], 20);
    h.tcode = 4'h3;
    send_hdr(h);
    repeat (10) @(negedge core_clk_in);
    cmp_cnt("dropped words", 0, host.got.size());
    run_row(rows[0], 21);
    // Reset in mid-packet under back-pressure, then a clean block write
    stall = 1'b1;
    send_hdr(mk_hdr(rows[5], 22));
    repeat (3) @(negedge core_clk_in);
    rst_n_in = 1'b0;
    @(negedge core_clk_in);
    cmp_bit("word_valid mid reset", 1'b0, word_valid_out);
    cmp_bit("hdr_ready mid reset", 1'b1, hdr_ready_out);
    cmp_bit("byte_ready mid reset", 1'b1, byte_ready_out);
    rst_n_in = 1'b1;
    host.got.delete();
    @(negedge core_clk_in);
    stall = 1'b0;
    run_row(rows[5], 23);
    give_verdict();
  end
endmodule : test_async_receive_packet_formatter
